// file: logic/serctl_pkg.sv
// shared constants for the serial control register port and its bus master
package serctl_pkg;
	// slave address and device register map
	localparam logic [4:0] DEV_ADDR_HI = 5'h12;
	localparam logic [7:0] REG_CHAN = 8'h00;
	localparam logic [7:0] REG_OUTC = 8'h01;
	localparam logic [7:0] REG_INC = 8'h02;
	localparam logic [7:0] RST_CHAN = 8'h00;
	localparam logic [7:0] RST_OUTC = 8'h07;
	localparam logic [7:0] RST_INC = 8'h02;
	localparam logic [7:0] MASK_CHAN = 8'h07;
	localparam logic [7:0] MASK_OUTC = 8'h0f;
	localparam logic [7:0] MASK_INC = 8'h03;
	localparam int CHAN_SRC_BIT = 2;
	localparam int OUTC_EN_SRC_BIT = 3;
	localparam int OUTC_EN_BIT = 2;
	localparam int OUTC_DRIVE_BIT = 1;
	localparam int OUTC_TERM_BIT = 0;
	localparam int INC_BOOST_BIT = 1;
	localparam int INC_INV_BIT = 0;
	// bus master register map on apb
	localparam logic [7:0] HREG_CMD = 8'h00;
	localparam logic [7:0] HREG_STAT = 8'h04;
	localparam logic [7:0] HREG_RDATA = 8'h08;
	localparam logic [7:0] HREG_ID = 8'h0c;
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_PTR_LSB = 8;
	localparam int CMD_OP_LSB = 16;
	localparam int CMD_CNT_LSB = 18;
	localparam int CMD_GO_BIT = 31;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_READ_CUR = 2'h2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NACK_BIT = 1;
	localparam int STAT_DONE_BIT = 2;
	// timing: one quarter of a bus clock period
	localparam int CLK_NS = 4;
	localparam int SCL_QUARTER_NS = 1000;
	localparam int SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_NS;
endpackage

// file: logic/serctl_if.sv
// two-wire control bus joining the bus master and the register port
interface serctl_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// open-drain wires with pull-up: low while any enabled driver pulls low
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
		input scl, input sda);
	modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// file: logic/serctl_device.sv
// serial control register port: two-wire slave with three control registers
//
// The two-wire slave port was chosen for this implementation.
module serctl_device
	import serctl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	serctl_if.device bus,
	input wire logic register_restore_n,
	input wire logic [1:0] bus_id_pins,
	input wire logic [1:0] input_pick_pins,
	input wire logic out_enable_pin,
	output logic [1:0] input_pick,
	output logic out_enable,
	output logic out_drive_level,
	output logic out_termination_on,
	output logic boost_level,
	output logic input_invert
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_PTR = 4'h3,
		ST_PTR_ACK = 4'h4,
		ST_WDAT = 4'h5,
		ST_WDAT_ACK = 4'h6,
		ST_RDAT = 4'h7,
		ST_RACK = 4'h8
	} dev_state_t;

	// unused register bits never reach storage and read as zero
	function automatic logic [7:0] reg_value(input logic [7:0] idx, input logic [7:0] c,
		input logic [7:0] o, input logic [7:0] i);
		logic [7:0] v;
		v = 8'h00;
		if (idx == REG_CHAN) v = c & MASK_CHAN;
		if (idx == REG_OUTC) v = o & MASK_OUTC;
		if (idx == REG_INC) v = i & MASK_INC;
		return v;
	endfunction

	// every pin passes two flops; bit 0 sda, 1 scl, 2 enable pin, 4:3 pick, 6:5 id, 7 restore
	logic [7:0] sync_a_r;
	logic [7:0] sync_b_r;
	logic [1:0] last_r;
	dev_state_t st_r, st_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic rw_r, rw_nxt;
	logic flag_r, flag_nxt;
	logic sda_oe_r, sda_oe_nxt;
	logic sda_o_r;
	logic wr_en;
	logic [7:0] chan_r;
	logic [7:0] outc_r;
	logic [7:0] inc_r;
	logic [1:0] pick_r;
	logic oen_r;
	logic drive_r;
	logic term_r;
	logic boost_r;
	logic inv_r;

	wire logic [7:0] pins_in = {register_restore_n, bus_id_pins, input_pick_pins,
		out_enable_pin, bus.scl, bus.sda};
	wire logic sda_s = sync_b_r[0];
	wire logic scl_s = sync_b_r[1];
	wire logic en_pin_s = sync_b_r[2];
	wire logic [1:0] pick_pins_s = sync_b_r[4:3];
	wire logic [1:0] id_s = sync_b_r[6:5];
	wire logic restore_n_s = sync_b_r[7];
	wire logic start_det = scl_s & last_r[1] & last_r[0] & ~sda_s;
	wire logic stop_det = scl_s & last_r[1] & ~last_r[0] & sda_s;
	wire logic scl_rise = scl_s & ~last_r[1];
	wire logic scl_fall = ~scl_s & last_r[1];
	wire logic [7:0] rx_byte = {sh_r[6:0], sda_s};
	wire logic addr_hit = rx_byte[7:1] == {DEV_ADDR_HI, id_s};
	wire logic [7:0] rd_value = reg_value(ptr_r, chan_r, outc_r, inc_r);
	wire logic last_bit = bit_r == 3'h7;

	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		flag_nxt = flag_r;
		sda_oe_nxt = sda_oe_r;
		wr_en = 1'b0;
		if (start_det) begin
			// repeated start keeps the pointer, so a read follows the last write
			st_nxt = ST_ADDR;
			bit_nxt = 3'h0;
			flag_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
		end else if (stop_det) begin
			st_nxt = ST_IDLE;
			flag_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
		end else begin
			case (st_r)
				ST_ADDR, ST_PTR, ST_WDAT: begin
					if (scl_rise) begin
						sh_nxt = rx_byte;
						bit_nxt = bit_r + 3'h1;
						if (last_bit) begin
							if (st_r == ST_ADDR) begin
								st_nxt = addr_hit ? ST_ADDR_ACK : ST_IDLE;
								rw_nxt = rx_byte[0];
							end else if (st_r == ST_PTR) begin
								ptr_nxt = rx_byte;
								st_nxt = ST_PTR_ACK;
							end else begin
								wr_en = 1'b1;
								st_nxt = ST_WDAT_ACK;
							end
						end
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WDAT_ACK: begin
					if (scl_fall) begin
						if (!flag_r) begin
							flag_nxt = 1'b1;
							sda_oe_nxt = 1'b1;
						end else begin
							flag_nxt = 1'b0;
							sda_oe_nxt = 1'b0;
							bit_nxt = 3'h0;
							if (st_r == ST_ADDR_ACK && rw_r) begin
								st_nxt = ST_RDAT;
								tx_nxt = rd_value;
								sda_oe_nxt = ~rd_value[7];
							end else if (st_r == ST_ADDR_ACK) begin
								st_nxt = ST_PTR;
							end else if (st_r == ST_PTR_ACK) begin
								st_nxt = ST_WDAT;
							end else begin
								// one data byte per write; the master stops or restarts
								st_nxt = ST_IDLE;
							end
						end
					end
				end
				ST_RDAT: begin
					if (scl_rise) begin
						bit_nxt = bit_r + 3'h1;
						if (last_bit) st_nxt = ST_RACK;
					end else if (scl_fall) begin
						tx_nxt = {tx_r[6:0], 1'b0};
						sda_oe_nxt = ~tx_r[6];
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						// pointer moves after every byte sent, acked or not
						ptr_nxt = ptr_r + 8'h01;
						if (!sda_s) flag_nxt = 1'b1;
						else st_nxt = ST_IDLE;
					end else if (scl_fall) begin
						sda_oe_nxt = 1'b0;
						if (flag_r) begin
							flag_nxt = 1'b0;
							st_nxt = ST_RDAT;
							bit_nxt = 3'h0;
							tx_nxt = rd_value;
							sda_oe_nxt = ~rd_value[7];
						end
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			// bus lines reset to their idle high level, so no false edge follows reset
			sync_a_r <= 8'h83;
			sync_b_r <= 8'h83;
			last_r <= 2'h3;
		end else if (clk_en) begin
			sync_a_r <= pins_in;
			sync_b_r <= sync_a_r;
			last_r <= sync_b_r[1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r <= ST_IDLE;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			flag_r <= 1'b0;
			sda_oe_r <= 1'b0;
			sda_o_r <= 1'b0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			flag_r <= flag_nxt;
			sda_oe_r <= sda_oe_nxt;
		end
	end

	// restore is level sensitive and beats a bus write in the same cycle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			chan_r <= RST_CHAN;
			outc_r <= RST_OUTC;
			inc_r <= RST_INC;
		end else if (clk_en) begin
			if (!restore_n_s) begin
				chan_r <= RST_CHAN;
				outc_r <= RST_OUTC;
				inc_r <= RST_INC;
			end else if (wr_en) begin
				if (ptr_r == REG_CHAN) chan_r <= rx_byte & MASK_CHAN;
				if (ptr_r == REG_OUTC) outc_r <= rx_byte & MASK_OUTC;
				if (ptr_r == REG_INC) inc_r <= rx_byte & MASK_INC;
			end
		end
	end

	wire logic [1:0] pick_sel = chan_r[CHAN_SRC_BIT] ? chan_r[1:0] : pick_pins_s;
	wire logic oen_sel = outc_r[OUTC_EN_SRC_BIT] ? outc_r[OUTC_EN_BIT] : en_pin_s;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pick_r <= 2'h0;
			oen_r <= 1'b0;
			drive_r <= 1'b0;
			term_r <= 1'b0;
			boost_r <= 1'b0;
			inv_r <= 1'b0;
		end else if (clk_en) begin
			pick_r <= pick_sel;
			oen_r <= oen_sel;
			drive_r <= outc_r[OUTC_DRIVE_BIT];
			term_r <= outc_r[OUTC_TERM_BIT];
			boost_r <= inc_r[INC_BOOST_BIT];
			inv_r <= inc_r[INC_INV_BIT];
		end
	end

	assign bus.dev_sda_oe = sda_oe_r;
	assign bus.dev_sda_o = sda_o_r;
	assign input_pick = pick_r;
	assign out_enable = oen_r;
	assign out_drive_level = drive_r;
	assign out_termination_on = term_r;
	assign boost_level = boost_r;
	assign input_invert = inv_r;
endmodule

// file: logic/serctl_host.sv
// two-wire bus master for the register port, ordered over apb
module serctl_host
	import serctl_pkg::*;
#(
	parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	serctl_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_START = 3'h1,
		HS_TX = 3'h2,
		HS_RXACK = 3'h3,
		HS_RX = 3'h4,
		HS_TXACK = 3'h5,
		HS_STOP = 3'h6
	} host_state_t;
	typedef enum logic [1:0] {
		SEG_AW = 2'h0,
		SEG_PTR = 2'h1,
		SEG_DAT = 2'h2,
		SEG_AR = 2'h3
	} seg_t;

	host_state_t st_r;
	seg_t seg_r;
	logic [15:0] div_r;
	logic [1:0] q_r;
	logic [2:0] bit_r;
	logic [7:0] txb_r;
	logic [7:0] rxb_r;
	logic [1:0] cnt_r;
	logic [1:0] op_r;
	logic [7:0] ptr_r;
	logic [7:0] data_r;
	logic [1:0] id_r;
	logic [31:0] rdata_r;
	logic nack_r;
	logic done_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic [1:0] sda_sync_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	wire logic busy = st_r != HS_IDLE;
	wire logic tick = busy && div_r == 16'(QUARTER_CYC - 1);
	wire logic sda_s = sda_sync_r[1];
	wire logic setup = psel & ~penable;
	wire logic wr_take = psel & penable & pready_r & pwrite;
	wire logic go = wr_take && paddr == HREG_CMD && pwdata[CMD_GO_BIT] && !busy;
	wire logic id_wr = wr_take && paddr == HREG_ID;
	wire logic mapped = paddr == HREG_CMD || paddr == HREG_STAT || paddr == HREG_RDATA ||
		paddr == HREG_ID;
	wire logic [31:0] stat_word = {29'h0, done_r, nack_r, busy};
	wire logic [31:0] rd_word = paddr == HREG_STAT ? stat_word :
		paddr == HREG_RDATA ? rdata_r :
		paddr == HREG_ID ? {30'h0, id_r} : 32'h0;
	wire logic last_bit = bit_r == 3'h7;
	wire logic [7:0] addr_byte = {DEV_ADDR_HI, id_r, seg_r == SEG_AR};

	// apb slave: no wait state, answer in the first access cycle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			id_r <= 2'h0;
		end else if (clk_en) begin
			pready_r <= setup;
			pslverr_r <= setup & ~mapped;
			if (setup) prdata_r <= rd_word;
			if (id_wr) id_r <= pwdata[1:0];
		end
	end

	// sda passes two flops before the bit sequencer samples it
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sda_sync_r <= 2'h3;
			div_r <= 16'h0;
			q_r <= 2'h0;
		end else if (clk_en) begin
			sda_sync_r <= {sda_sync_r[0], bus.sda};
			div_r <= (tick || !busy) ? 16'h0 : div_r + 16'h1;
			if (!busy) q_r <= 2'h0;
			else if (tick) q_r <= q_r + 2'h1;
		end
	end

	// each bit: q0 set sda, q1 release scl, q2 sample when receiving, q3 pull scl low
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r <= HS_IDLE;
			seg_r <= SEG_AW;
			bit_r <= 3'h0;
			txb_r <= 8'h0;
			rxb_r <= 8'h0;
			cnt_r <= 2'h0;
			op_r <= OP_WRITE;
			ptr_r <= 8'h0;
			data_r <= 8'h0;
			rdata_r <= 32'h0;
			nack_r <= 1'b0;
			done_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (clk_en) begin
			if (go) begin
				st_r <= HS_START;
				op_r <= pwdata[CMD_OP_LSB +: 2];
				ptr_r <= pwdata[CMD_PTR_LSB +: 8];
				data_r <= pwdata[CMD_DATA_LSB +: 8];
				cnt_r <= pwdata[CMD_CNT_LSB +: 2];
				seg_r <= pwdata[CMD_OP_LSB +: 2] == OP_READ_CUR ? SEG_AR : SEG_AW;
				rdata_r <= 32'h0;
				nack_r <= 1'b0;
				done_r <= 1'b0;
			end else if (tick) begin
				case (st_r)
					HS_START: begin
						if (q_r == 2'h0) sda_oe_r <= 1'b0;
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h2) sda_oe_r <= 1'b1;
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							st_r <= HS_TX;
							txb_r <= addr_byte;
							bit_r <= 3'h0;
						end
					end
					HS_TX: begin
						if (q_r == 2'h0) sda_oe_r <= ~txb_r[7];
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							txb_r <= {txb_r[6:0], 1'b0};
							bit_r <= bit_r + 3'h1;
							if (last_bit) st_r <= HS_RXACK;
						end
					end
					HS_RXACK: begin
						if (q_r == 2'h0) sda_oe_r <= 1'b0;
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h2) nack_r <= sda_s;
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							bit_r <= 3'h0;
							if (nack_r) st_r <= HS_STOP;
							else if (seg_r == SEG_AW) begin
								seg_r <= SEG_PTR;
								txb_r <= ptr_r;
								st_r <= HS_TX;
							end else if (seg_r == SEG_PTR && op_r == OP_WRITE) begin
								seg_r <= SEG_DAT;
								txb_r <= data_r;
								st_r <= HS_TX;
							end else if (seg_r == SEG_PTR) begin
								seg_r <= SEG_AR;
								st_r <= HS_START;
							end else if (seg_r == SEG_DAT) st_r <= HS_STOP;
							else st_r <= HS_RX;
						end
					end
					HS_RX: begin
						if (q_r == 2'h0) sda_oe_r <= 1'b0;
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h2) begin
							rxb_r <= {rxb_r[6:0], sda_s};
							if (last_bit) rdata_r <= {rdata_r[23:0], rxb_r[6:0], sda_s};
						end
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							bit_r <= bit_r + 3'h1;
							if (last_bit) st_r <= HS_TXACK;
						end
					end
					HS_TXACK: begin
						if (q_r == 2'h0) sda_oe_r <= cnt_r != 2'h0;
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							bit_r <= 3'h0;
							if (cnt_r != 2'h0) begin
								cnt_r <= cnt_r - 2'h1;
								st_r <= HS_RX;
							end else st_r <= HS_STOP;
						end
					end
					HS_STOP: begin
						if (q_r == 2'h0) sda_oe_r <= 1'b1;
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h2) sda_oe_r <= 1'b0;
						if (q_r == 2'h3) begin
							st_r <= HS_IDLE;
							done_r <= 1'b1;
						end
					end
					default: st_r <= HS_IDLE;
				endcase
			end
		end
	end

	assign bus.host_scl_oe = scl_oe_r;
	assign bus.host_sda_oe = sda_oe_r;
	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule

// file: verif/serctl_bus_asserts.sv
// assertion checker for the two-wire bus between master and register port
module serctl_bus_asserts
	import serctl_pkg::*;
#(
	parameter int Q = 10
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic [1:0] bus_id_pins
);
	timeunit 1ns;
	timeprecision 100ps;
	// ack plus eight zero bits is the longest legal pull, with sync slack
	localparam int RUN_MAX = 40 * Q + 8;
	logic scl_q_r;
	logic sda_q_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] byte_r;
	int run_r;
	wire scl_rise = scl & ~scl_q_r;
	wire start_seen = scl & scl_q_r & sda_q_r & ~sda;
	wire addr_miss = byte_r[7:1] != {DEV_ADDR_HI, bus_id_pins};
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			bit_cnt_r <= 4'hf;
			byte_r <= 8'h00;
			run_r <= 0;
		end else begin
			scl_q_r <= scl;
			sda_q_r <= sda;
			run_r <= dev_sda_oe ? run_r + 1 : 0;
			if (start_seen)
				bit_cnt_r <= 4'h0;
			else if (scl_rise && bit_cnt_r != 4'hf)
				bit_cnt_r <= bit_cnt_r + 4'h1;
			if (scl_rise)
				byte_r <= {byte_r[6:0], sda};
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	property p_idle_after_reset;
		$fell(reset) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe && !host_scl_o
			&& !host_sda_o && !dev_sda_o;
	endproperty
	a_idle_after_reset: assert property (p_idle_after_reset) else $error("busy after reset");
	property p_ack_on_match;
		scl_rise && bit_cnt_r == 4'h8 |-> sda == addr_miss;
	endproperty
	a_ack_on_match: assert property (p_ack_on_match) else $error("wrong address answer");
	property p_quiet_in_address;
		bit_cnt_r < 4'h8 |-> !dev_sda_oe;
	endproperty
	a_quiet_in_address: assert property (p_quiet_in_address) else $error("drove in address");
	property p_no_dev_start;
		s_start |-> host_sda_oe;
	endproperty
	a_no_dev_start: assert property (p_no_dev_start) else $error("start not by master");
	property p_dev_edge_low;
		$changed(dev_sda_oe) |-> !scl && !dev_sda_o;
	endproperty
	a_dev_edge_low: assert property (p_dev_edge_low) else $error("moved while clock high");
	property p_scl_high_time;
		$rose(scl) |-> scl [*8];
	endproperty
	a_scl_high_time: assert property (p_scl_high_time) else $error("clock high too short");
	property p_dev_run;
		run_r <= RUN_MAX;
	endproperty
	a_dev_run: assert property (p_dev_run) else $error("port held data line too long");
	property p_release_after_stop;
		s_stop |=> !dev_sda_oe [*8];
	endproperty
	a_release_after_stop: assert property (p_release_after_stop) else $error("stop held");
endmodule

// file: verif/tb.sv
// self-checking bench: apb-driven bus master against the register port
module tb
	import serctl_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int Q = 10;
	logic sys_clk, reset, restore_n, en_pin, psel, penable, pwrite, pready, pslverr;
	logic [1:0] id_pins, pick_pins, input_pick;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic out_enable, out_drive_level, out_termination_on, boost_level, input_invert;
	int error_cnt = 0;
	int total_checks = 0;
	serctl_if bus_if();
	serctl_device serctl_device_inst(.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
		.bus(bus_if), .register_restore_n(restore_n), .bus_id_pins(id_pins),
		.input_pick_pins(pick_pins), .out_enable_pin(en_pin), .input_pick(input_pick),
		.out_enable(out_enable), .out_drive_level(out_drive_level),
		.out_termination_on(out_termination_on), .boost_level(boost_level),
		.input_invert(input_invert));
	serctl_host #(.QUARTER_CYC(Q)) serctl_host_inst(.sys_clk(sys_clk), .reset(reset),
		.clk_en(1'b1), .bus(bus_if), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	serctl_bus_asserts #(.Q(Q)) serctl_bus_asserts_inst(.sys_clk(sys_clk), .reset(reset),
		.host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe),
		.host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
		.dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl),
		.sda(bus_if.sda), .bus_id_pins(id_pins));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic hang(input string name);
		error_cnt++;
		$display("mismatch %s expected answer seen timeout", name);
		finish_test();
	endtask
	// request held from setup until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) hang("pready");
			@(posedge sys_clk);
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(input logic [1:0] o, input logic [7:0] ptr, input logic [7:0] dat,
		input logic [1:0] cnt, output logic [31:0] rd, output logic nk);
		logic [31:0] s;
		logic e;
		int n;
		apb(1'b1, HREG_CMD, {1'b1, 11'h000, cnt, o, ptr, dat}, s, e);
		n = 0;
		s = 32'h0;
		while (s[STAT_DONE_BIT] !== 1'b1) begin
			n++;
			if (n > 3000) hang("done");
			apb(1'b0, HREG_STAT, 32'h0, s, e);
		end
		nk = s[STAT_NACK_BIT];
		apb(1'b0, HREG_RDATA, 32'h0, rd, e);
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
		logic [31:0] r;
		logic nk;
		op(OP_WRITE, ptr, dat, 2'h0, r, nk);
		chk("write ack", 32'h0, {31'h0, nk});
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp, input string name);
		logic [31:0] r;
		logic nk;
		op(OP_READ, ptr, 8'h00, 2'h0, r, nk);
		chk(name, {24'h0, exp}, {24'h0, r[7:0]});
	endtask
	// outputs pass one register after a two-flop pin sync, so give them a few cycles
	task automatic outs(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
		repeat (6) @(negedge sys_clk);
		chk("input_pick", r0[2] ? r0[1:0] : pick_pins, input_pick);
		chk("out_enable", r1[3] ? r1[2] : en_pin, out_enable);
		chk("out_drive_level", r1[1], out_drive_level);
		chk("out_termination_on", r1[0], out_termination_on);
		chk("boost_level", r2[1], boost_level);
		chk("input_invert", r2[0], input_invert);
	endtask
	task automatic t_defaults();
		logic [31:0] r;
		logic e;
		apb(1'b1, HREG_ID, 32'h1, r, e);
		apb(1'b0, HREG_ID, 32'h0, r, e);
		chk("id readback", 32'h1, r);
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk("unmapped pslverr", 32'h1, {31'h0, e});
		outs(RST_CHAN, RST_OUTC, RST_INC);
		rd(REG_CHAN, RST_CHAN, "chan default");
		rd(REG_OUTC, RST_OUTC, "outc default");
		rd(REG_INC, RST_INC, "inc default");
	endtask
	task automatic t_fields();
		for (int c = 0; c < 4; c++) begin
			wr(REG_CHAN, 8'hfc | 8'(c));
			outs(8'h04 | 8'(c), RST_OUTC, RST_INC);
		end
		rd(REG_CHAN, 8'h07, "chan masked");
		wr(REG_CHAN, 8'h03);
		@(posedge sys_clk);
		pick_pins <= 2'h2;
		outs(8'h03, RST_OUTC, RST_INC);
		wr(REG_OUTC, 8'hf8);
		outs(8'h03, 8'h08, RST_INC);
		wr(REG_OUTC, 8'h06);
		@(posedge sys_clk);
		en_pin <= 1'b0;
		outs(8'h03, 8'h06, RST_INC);
		wr(REG_INC, 8'hfd);
		outs(8'h03, 8'h06, 8'h01);
		rd(REG_INC, 8'h01, "inc masked");
	endtask
	task automatic t_burst();
		logic [31:0] r;
		logic nk;
		op(OP_READ, REG_CHAN, 8'h00, 2'h1, r, nk);
		chk("burst pair", 32'h0306, {16'h0, r[15:0]});
		op(OP_READ_CUR, 8'h00, 8'h00, 2'h0, r, nk);
		chk("byte after nack", 32'h01, {24'h0, r[7:0]});
		wr(REG_OUTC, 8'h0e);
		op(OP_READ_CUR, 8'h00, 8'h00, 2'h0, r, nk);
		chk("pointer kept", 32'h0e, {24'h0, r[7:0]});
	endtask
	task automatic t_address();
		logic [31:0] r;
		logic e;
		logic nk;
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			id_pins <= 2'(i);
			apb(1'b1, HREG_ID, 32'(i), r, e);
			wr(REG_INC, 8'(i));
			rd(REG_INC, 8'(i), "id match");
		end
		apb(1'b1, HREG_ID, 32'h1, r, e);
		op(OP_WRITE, REG_INC, 8'h02, 2'h0, r, nk);
		chk("foreign nack", 32'h1, {31'h0, nk});
		apb(1'b1, HREG_ID, 32'h3, r, e);
		rd(REG_INC, 8'h03, "foreign ignored");
	endtask
	task automatic t_restore();
		@(posedge sys_clk);
		restore_n <= 1'b0;
		outs(RST_CHAN, RST_OUTC, RST_INC);
		@(posedge sys_clk);
		restore_n <= 1'b1;
		rd(REG_OUTC, RST_OUTC, "outc restored");
		rd(REG_INC, RST_INC, "inc restored");
	endtask
	initial begin
		reset = 1'b1;
		restore_n = 1'b1;
		en_pin = 1'b1;
		id_pins = 2'h1;
		pick_pins = 2'h1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		t_defaults();
		t_fields();
		t_burst();
		t_address();
		t_restore();
		finish_test();
	end
endmodule
